// >>> pkg/opaddr_pkg.sv
// shared constants, types and helpers of the operand address generator
// Summary of operation
// - pointer value addresses RAM bank by suffix
// - data index reaches low sixteen words only
// - double indirect: RAM word gives program address
// - program memory through indirection is read-only
// - data index indirection also reads program memory
// - stored program address incremented, written back
// - accumulator indirect reads program memory at accumulator
// - direct mode moves accumulator to/from RAM
// - direct address bit eight selects bank
// - long immediate copies sixteen-bit word
// - short immediate loads only a pointer
// - pointer RAM access supports four update variants
// - pointer program access supports same variants
// - conditional instruction acts only when true
// - unsigned less-than equals carry set
// - unsigned greater-equal equals carry clear
package opaddr_pkg;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned RAM_AW          = 8;
    localparam int unsigned PTR_W           = 8;
    localparam int unsigned DIRECT_BANK_BIT = 8;
    localparam int unsigned DREG_BANK_BIT   = 2;
    localparam logic [3:0]  REG_STATUS_WORD = 4'h8;
    localparam logic [3:0]  REG_LOOP_CFG    = 4'h9;
    localparam logic [3:0]  REG_STATE       = 4'ha;
    localparam logic [7:0]  PTR_RST         = 8'h00;
    localparam logic [1:0]  PAGE_RST        = 2'h0;
    localparam logic [2:0]  LOOP_RST        = 3'h3;
    localparam logic [15:0] MIND_STEP       = 16'h0001;
    localparam logic [7:0]  PTR_STEP        = 8'h01;

    typedef enum logic [3:0] {
        M_PTR, M_DREG, M_MIND_PTR, M_MIND_DREG, M_ACC, M_DIRECT, M_LIMM, M_SIMM
    } addr_mode_t;

    typedef enum logic [1:0] {STEP_NONE, STEP_INC, STEP_LOOP_DEC, STEP_LOOP_INC} ptr_step_t;

    typedef enum logic [4:0] {
        CC_CARRY, CC_NO_CARRY, CC_ZERO, CC_NOT_ZERO, CC_MINUS, CC_PLUS,
        CC_OVERFLOW, CC_NO_OVERFLOW, CC_USER_FLAG_ZERO, CC_NOT_USER_FLAG_ZERO,
        CC_USER_FLAG_ONE, CC_NOT_USER_FLAG_ONE, CC_IRQ_ENABLED_COND,
        CC_NOT_IRQ_ENABLED, CC_FALSE, CC_UNSIGNED_LT_COND, CC_UNSIGNED_GE_COND
    } cond_code_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RAM_WAIT, ST_RAM_DATA, ST_MIND_WAIT, ST_MIND_DATA, ST_PM_WAIT, ST_PM_DATA
    } fsm_state_t;

    typedef struct packed {
        logic carry;
        logic zero;
        logic minus;
        logic overflow;
        logic user_flag_zero;
        logic user_flag_one;
        logic irq_enabled;
    } core_flags_t;

    typedef struct packed {
        addr_mode_t  mode;
        ptr_step_t   step;
        logic        cond_en;
        cond_code_t  cond;
        logic [2:0]  ptr_sel;
        logic [8:0]  field;
        logic        write;
        logic        dst_ptr;
        logic [15:0] imm;
        logic [15:0] acc;
    } op_req_t;

    typedef struct packed {
        logic        en;
        logic        we;
        logic        bank;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } ram_req_t;

    // modes whose operand comes from program memory through a RAM word
    function automatic logic is_mind(input addr_mode_t m);
        return (m == M_MIND_PTR) || (m == M_MIND_DREG);
    endfunction

    // modes that touch data RAM in the first access cycle
    function automatic logic uses_ram(input addr_mode_t m);
        return (m == M_PTR) || (m == M_DREG) || (m == M_DIRECT) || is_mind(m);
    endfunction
endpackage

// >>> hdl/ptr_update.sv
// pointer post-update stepping with circular wrap
module ptr_update (
    input  wire logic [7:0]            ptr,
    input  wire opaddr_pkg::ptr_step_t step,
    input  wire logic [2:0]            loop_log2,
    output logic [7:0]                 ptr_next
);
    logic [7:0] mask;

    // loop steps only move the low bits, so the buffer base never drifts
    always_comb begin
        mask = 8'((8'h01 << loop_log2) - 8'h01);
        unique case (step)
            opaddr_pkg::STEP_NONE:     ptr_next = ptr;
            opaddr_pkg::STEP_INC:      ptr_next = 8'(ptr + opaddr_pkg::PTR_STEP);
            opaddr_pkg::STEP_LOOP_DEC: ptr_next = (ptr & ~mask) | (8'(ptr - opaddr_pkg::PTR_STEP) & mask);
            opaddr_pkg::STEP_LOOP_INC: ptr_next = (ptr & ~mask) | (8'(ptr + opaddr_pkg::PTR_STEP) & mask);
        endcase
    end
endmodule // ptr_update

// >>> hdl/cond_eval.sv
// condition code evaluation against the core flags
module cond_eval (
    input  wire opaddr_pkg::cond_code_t  code,
    input  wire opaddr_pkg::core_flags_t flags,
    output logic                         holds
);
    // unsigned compares reuse the carry, no separate flag exists
    always_comb begin
        unique case (code)
            opaddr_pkg::CC_CARRY:              holds = flags.carry;
            opaddr_pkg::CC_NO_CARRY:           holds = !flags.carry;
            opaddr_pkg::CC_ZERO:               holds = flags.zero;
            opaddr_pkg::CC_NOT_ZERO:           holds = !flags.zero;
            opaddr_pkg::CC_MINUS:              holds = flags.minus;
            opaddr_pkg::CC_PLUS:               holds = !flags.minus;
            opaddr_pkg::CC_OVERFLOW:           holds = flags.overflow;
            opaddr_pkg::CC_NO_OVERFLOW:        holds = !flags.overflow;
            opaddr_pkg::CC_USER_FLAG_ZERO:     holds = flags.user_flag_zero;
            opaddr_pkg::CC_NOT_USER_FLAG_ZERO: holds = !flags.user_flag_zero;
            opaddr_pkg::CC_USER_FLAG_ONE:      holds = flags.user_flag_one;
            opaddr_pkg::CC_NOT_USER_FLAG_ONE:  holds = !flags.user_flag_one;
            opaddr_pkg::CC_IRQ_ENABLED_COND:   holds = flags.irq_enabled;
            opaddr_pkg::CC_NOT_IRQ_ENABLED:    holds = !flags.irq_enabled;
            opaddr_pkg::CC_FALSE:              holds = 1'b0;
            opaddr_pkg::CC_UNSIGNED_LT_COND:   holds = flags.carry;
            opaddr_pkg::CC_UNSIGNED_GE_COND:   holds = !flags.carry;
            default:                           holds = 1'b0;
        endcase
    end
endmodule // cond_eval

// >>> hdl/operand_address_generator.sv
// operand addressing sequencer with pointer file and condition gating
//
// Design decisions made here: strobed register access and the address map.
module operand_address_generator #(
    parameter int unsigned PTR_CNT = 8
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [15:0]                  reg_rdata,
    input  wire logic                    op_valid,
    input  wire opaddr_pkg::op_req_t     op_in,
    input  wire opaddr_pkg::core_flags_t flags_in,
    output logic                         op_busy,
    output logic                         op_done,
    output logic                         op_executed,
    output logic                         op_refused,
    output logic [15:0]                  op_result,
    output opaddr_pkg::ram_req_t         ram_req,
    input  wire logic [15:0]             ram_rdata,
    output logic                         pm_rd,
    output logic [15:0]                  pm_addr,
    input  wire logic [15:0]             pm_rdata
);
    // the decode assumes eight pointers, selector bit two is the bank
    if (PTR_CNT != 8) begin : g_bad_ptr_cnt
        $error("PTR_CNT must be 8");
    end

    logic [7:0]             ptr_q [PTR_CNT];
    logic [1:0]             page_q;
    logic [2:0]             loop_q;
    opaddr_pkg::fsm_state_t state_q;
    logic                   busy_q;
    logic                   done_q;
    logic                   exec_q;
    logic                   refused_q;
    logic [15:0]            result_q;
    opaddr_pkg::ram_req_t   ram_req_q;
    logic                   pm_rd_q;
    logic [15:0]            pm_addr_q;
    logic                   wb_bank_q;
    logic [7:0]             wb_addr_q;
    logic [15:0]            reg_rdata_q;

    logic                   take;
    logic                   cc_holds;
    logic                   cond_ok;
    logic                   go;
    logic                   refuse;
    logic                   act;
    logic [7:0]             sel_ptr;
    logic [7:0]             ptr_next;
    logic                   eff_bank;
    logic [7:0]             eff_addr;

    assign sel_ptr = ptr_q[op_in.ptr_sel];
    assign take    = op_valid && !busy_q;
    assign cond_ok = !op_in.cond_en || cc_holds;
    assign go      = take && cond_ok;
    assign act     = go && !refuse;

    cond_eval u_cond (
        .code  (op_in.cond),
        .flags (flags_in),
        .holds (cc_holds)
    );

    ptr_update u_step (
        .ptr       (sel_ptr),
        .step      (op_in.step),
        .loop_log2 (loop_q),
        .ptr_next  (ptr_next)
    );

    // forbidden forms are turned away before any memory is touched
    always_comb begin
        refuse = 1'b0;
        if ((opaddr_pkg::is_mind(op_in.mode) || op_in.mode == opaddr_pkg::M_ACC) && op_in.write) begin
            refuse = 1'b1;
        end
        if (op_in.mode == opaddr_pkg::M_SIMM && !op_in.dst_ptr) begin
            refuse = 1'b1;
        end
    end

    // effective data RAM address of the first access
    always_comb begin
        eff_bank = op_in.ptr_sel[2];
        eff_addr = sel_ptr;
        unique case (op_in.mode)
            opaddr_pkg::M_DREG, opaddr_pkg::M_MIND_DREG: begin
                eff_bank = op_in.field[opaddr_pkg::DREG_BANK_BIT];
                eff_addr = {4'h0, page_q, op_in.field[1:0]};
            end
            opaddr_pkg::M_DIRECT: begin
                eff_bank = op_in.field[opaddr_pkg::DIRECT_BANK_BIT];
                eff_addr = op_in.field[7:0];
            end
            default: begin
            end
        endcase
    end

    // sequencer: one operation at a time, busy blocks the next
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= opaddr_pkg::ST_IDLE;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            exec_q    <= 1'b0;
            refused_q <= 1'b0;
            result_q  <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                opaddr_pkg::ST_IDLE: begin
                    if (take) begin
                        exec_q    <= act;
                        refused_q <= go && refuse;
                        if (!act) begin
                            done_q <= 1'b1;
                        end else begin
                            unique case (op_in.mode)
                                opaddr_pkg::M_LIMM: begin
                                    result_q <= op_in.imm;
                                    done_q   <= 1'b1;
                                end
                                opaddr_pkg::M_SIMM: begin
                                    done_q <= 1'b1;
                                end
                                opaddr_pkg::M_ACC: begin
                                    state_q <= opaddr_pkg::ST_PM_WAIT;
                                    busy_q  <= 1'b1;
                                end
                                opaddr_pkg::M_MIND_PTR, opaddr_pkg::M_MIND_DREG: begin
                                    state_q <= opaddr_pkg::ST_MIND_WAIT;
                                    busy_q  <= 1'b1;
                                end
                                default: begin
                                    if (op_in.write) begin
                                        done_q <= 1'b1;
                                    end else begin
                                        state_q <= opaddr_pkg::ST_RAM_WAIT;
                                        busy_q  <= 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                end
                opaddr_pkg::ST_RAM_WAIT: state_q <= opaddr_pkg::ST_RAM_DATA;
                opaddr_pkg::ST_RAM_DATA: begin
                    result_q <= ram_rdata;
                    done_q   <= 1'b1;
                    busy_q   <= 1'b0;
                    state_q  <= opaddr_pkg::ST_IDLE;
                end
                opaddr_pkg::ST_MIND_WAIT: state_q <= opaddr_pkg::ST_MIND_DATA;
                opaddr_pkg::ST_MIND_DATA: state_q <= opaddr_pkg::ST_PM_WAIT;
                opaddr_pkg::ST_PM_WAIT:   state_q <= opaddr_pkg::ST_PM_DATA;
                opaddr_pkg::ST_PM_DATA: begin
                    result_q <= pm_rdata;
                    done_q   <= 1'b1;
                    busy_q   <= 1'b0;
                    state_q  <= opaddr_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= opaddr_pkg::ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // data RAM port: first access, then the indirect write-back
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_req_q <= '0;
            wb_bank_q <= 1'b0;
            wb_addr_q <= 8'h00;
        end else begin
            ram_req_q.en <= 1'b0;
            ram_req_q.we <= 1'b0;
            if (state_q == opaddr_pkg::ST_IDLE && act && opaddr_pkg::uses_ram(op_in.mode)) begin
                ram_req_q.en    <= 1'b1;
                ram_req_q.we    <= op_in.write;
                ram_req_q.bank  <= eff_bank;
                ram_req_q.addr  <= eff_addr;
                ram_req_q.wdata <= op_in.acc;
                wb_bank_q       <= eff_bank;
                wb_addr_q       <= eff_addr;
            end else if (state_q == opaddr_pkg::ST_MIND_DATA) begin
                ram_req_q.en    <= 1'b1;
                ram_req_q.we    <= 1'b1;
                ram_req_q.bank  <= wb_bank_q;
                ram_req_q.addr  <= wb_addr_q;
                ram_req_q.wdata <= 16'(ram_rdata + opaddr_pkg::MIND_STEP);
            end
        end
    end

    // program memory port is read-only, no write strobe exists at all
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_rd_q   <= 1'b0;
            pm_addr_q <= 16'h0000;
        end else begin
            pm_rd_q <= 1'b0;
            if (state_q == opaddr_pkg::ST_IDLE && act && op_in.mode == opaddr_pkg::M_ACC) begin
                pm_rd_q   <= 1'b1;
                pm_addr_q <= op_in.acc;
            end else if (state_q == opaddr_pkg::ST_MIND_DATA) begin
                pm_rd_q   <= 1'b1;
                pm_addr_q <= ram_rdata;
            end
        end
    end

    // pointer file: an executing operation wins over a software write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PTR_CNT; i++) begin
                ptr_q[i] <= opaddr_pkg::PTR_RST;
            end
        end else begin
            if (reg_wr && reg_addr < opaddr_pkg::REG_STATUS_WORD) begin
                ptr_q[reg_addr[2:0]] <= reg_wdata[7:0];
            end
            if (state_q == opaddr_pkg::ST_IDLE && act) begin
                if (op_in.mode == opaddr_pkg::M_SIMM) begin
                    ptr_q[op_in.ptr_sel] <= op_in.imm[7:0];
                end else if (op_in.mode == opaddr_pkg::M_PTR || op_in.mode == opaddr_pkg::M_MIND_PTR) begin
                    ptr_q[op_in.ptr_sel] <= ptr_next;
                end
            end
        end
    end

    // status word page bits and loop buffer size
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= opaddr_pkg::PAGE_RST;
            loop_q <= opaddr_pkg::LOOP_RST;
        end else if (reg_wr) begin
            if (reg_addr == opaddr_pkg::REG_STATUS_WORD) begin
                page_q <= reg_wdata[1:0];
            end
            if (reg_addr == opaddr_pkg::REG_LOOP_CFG) begin
                loop_q <= reg_wdata[2:0];
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 16'h0000;
        end else begin
            reg_rdata_q <= 16'h0000;
            if (reg_rd) begin
                if (reg_addr < opaddr_pkg::REG_STATUS_WORD) begin
                    reg_rdata_q <= {8'h00, ptr_q[reg_addr[2:0]]};
                end else if (reg_addr == opaddr_pkg::REG_STATUS_WORD) begin
                    reg_rdata_q <= {14'h0000, page_q};
                end else if (reg_addr == opaddr_pkg::REG_LOOP_CFG) begin
                    reg_rdata_q <= {13'h0000, loop_q};
                end else if (reg_addr == opaddr_pkg::REG_STATE) begin
                    reg_rdata_q <= {13'h0000, refused_q, exec_q, busy_q};
                end
            end
        end
    end

    assign reg_rdata   = reg_rdata_q;
    assign op_busy     = busy_q;
    assign op_done     = done_q;
    assign op_executed = exec_q;
    assign op_refused  = refused_q;
    assign op_result   = result_q;
    assign ram_req     = ram_req_q;
    assign pm_rd       = pm_rd_q;
    assign pm_addr     = pm_addr_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic start_mind;
    logic start_read;
    assign start_mind = act && state_q == opaddr_pkg::ST_IDLE && opaddr_pkg::is_mind(op_in.mode);
    assign start_read = act && !op_in.write && (op_in.mode == opaddr_pkg::M_PTR);

    sequence s_mind_fetch;
        ##1 (ram_req.en && !ram_req.we) ##2 (pm_rd && ram_req.en && ram_req.we);
    endsequence

    sequence s_mind_finish;
        ##2 op_done;
    endsequence

    a_ptr_ram_addr: assert property (take && act && op_in.mode == opaddr_pkg::M_PTR |=>
        ram_req.en && ram_req.addr == $past(sel_ptr) && ram_req.bank == $past(op_in.ptr_sel[2]))
        else $error("pointer access used the wrong address");

    a_dreg_low_words: assert property (act && op_in.mode == opaddr_pkg::M_DREG |=>
        ram_req.en && ram_req.addr[7:4] == 4'h0 && ram_req.addr[3:2] == page_q)
        else $error("data index access left the low sixteen words");

    a_mind_sequence: assert property (start_mind |-> s_mind_fetch ##0 s_mind_finish)
        else $error("indirect program fetch out of order");

    a_mind_address: assert property (state_q == opaddr_pkg::ST_MIND_DATA |=>
        pm_rd && pm_addr == $past(ram_rdata))
        else $error("program address not taken from RAM word");

    a_mind_writeback: assert property (state_q == opaddr_pkg::ST_MIND_DATA |=>
        ram_req.we && ram_req.wdata == 16'($past(ram_rdata) + 16'h0001) && ram_req.addr == wb_addr_q)
        else $error("stored program address not incremented");

    a_pm_read_only: assert property (take && cond_ok && op_in.write &&
        (opaddr_pkg::is_mind(op_in.mode) || op_in.mode == opaddr_pkg::M_ACC) |=>
        !pm_rd && !ram_req.en && op_refused && op_done)
        else $error("write through program indirection was not refused");

    a_acc_pm_read: assert property (act && op_in.mode == opaddr_pkg::M_ACC |=>
        pm_rd && pm_addr == $past(op_in.acc) ##2 op_done && op_result == $past(pm_rdata))
        else $error("accumulator indirect read wrong");

    a_direct_bank: assert property (act && op_in.mode == opaddr_pkg::M_DIRECT |=>
        ram_req.bank == $past(op_in.field[8]) && ram_req.addr == $past(op_in.field[7:0]))
        else $error("direct address bank select wrong");

    a_limm_copy: assert property (act && op_in.mode == opaddr_pkg::M_LIMM |=>
        op_done && op_result == $past(op_in.imm))
        else $error("long immediate not copied");

    a_simm_target: assert property (take && cond_ok && op_in.mode == opaddr_pkg::M_SIMM && !op_in.dst_ptr |=>
        op_refused && !op_executed)
        else $error("short immediate accepted for a non-pointer target");

    a_ptr_read_lat: assert property (start_read && take |=> !op_done ##1 !op_done ##1
        op_done && op_result == $past(ram_rdata))
        else $error("pointer read latency wrong");

    a_cond_false: assert property (take && !cond_ok |=>
        op_done && !op_executed && !ram_req.en && !pm_rd)
        else $error("false condition still had an effect");

    a_ult_carry: assert property (op_in.cond == opaddr_pkg::CC_UNSIGNED_LT_COND |->
        cc_holds == flags_in.carry)
        else $error("unsigned less-than differs from carry");

    a_uge_no_carry: assert property (op_in.cond == opaddr_pkg::CC_UNSIGNED_GE_COND |->
        cc_holds == !flags_in.carry)
        else $error("unsigned greater-equal differs from no carry");

    a_loop_wrap: assert property (act && op_in.step == opaddr_pkg::STEP_LOOP_INC &&
        op_in.mode == opaddr_pkg::M_PTR && loop_q != 3'h0
        |->
        ((ptr_next ^ sel_ptr) & ~8'((8'h01 << loop_q) - 8'h01)) == 8'h00 &&
        ((ptr_next ^ 8'(sel_ptr + 8'h01)) & 8'((8'h01 << loop_q) - 8'h01)) == 8'h00)
        else $error("loop step left its buffer");

    a_false_code: assert property (op_in.cond == opaddr_pkg::CC_FALSE |-> !cc_holds)
        else $error("false condition evaluated true");
endmodule // operand_address_generator

// >>> verif/mem_model.sv
// data ram banks and program memory seen by the address generator
module mem_model (
    input  wire logic                 ref_clk,
    input  wire opaddr_pkg::ram_req_t ram_req,
    output logic [15:0]               ram_rdata,
    input  wire logic                 pm_rd,
    input  wire logic [15:0]          pm_addr,
    output logic [15:0]               pm_rdata
);
    logic [15:0] ram_q [2][256];
    initial begin
        ram_rdata = 16'h0;
        pm_rdata = 16'h0;
    end
    // stale read data flips each cycle so a late sample never matches
    always @(posedge ref_clk) begin
        ram_rdata <= ~ram_rdata;
        pm_rdata <= ~pm_rdata;
        if (ram_req.en && ram_req.we)
            ram_q[ram_req.bank][ram_req.addr] <= ram_req.wdata;
        if (ram_req.en && !ram_req.we)
            ram_rdata <= ram_q[ram_req.bank][ram_req.addr];
        if (pm_rd)
            pm_rdata <= pm_addr ^ 16'hc3a5; // program word derived from address
    end
endmodule // mem_model

// >>> verif/operand_address_generator_test.sv
// self-checking bench of the operand address generator
module operand_address_generator_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, op_result, ram_rdata, pm_addr, pm_rdata, d, p;
    logic op_busy, op_done, op_executed, op_refused, pm_rd;
    opaddr_pkg::op_req_t op_in = '0;
    opaddr_pkg::core_flags_t flags_in = '0;
    opaddr_pkg::ram_req_t ram_req;
    logic [17:0] exp_q[$];
    logic [17:0] e;
    logic [31:0] seed = 32'h3acf;
    logic [7:0] a;
    int fails = 0, total_checks = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    operand_address_generator #(.PTR_CNT(8)) dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .op_valid, .op_in, .flags_in, .op_busy, .op_done, .op_executed,
        .op_refused, .op_result, .ram_req, .ram_rdata, .pm_rd, .pm_addr, .pm_rdata);
    mem_model mem_u (.ref_clk, .ram_req, .ram_rdata, .pm_rd, .pm_addr, .pm_rdata);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [16:0] g, input logic [16:0] x);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [3:0] i, input logic [15:0] x);
        @(posedge ref_clk) reg_rd <= 1'b1;
        reg_addr <= i;
        @(posedge ref_clk) reg_rd <= 1'b0;
        @(negedge ref_clk) chk({1'b0, reg_rdata}, {1'b0, x});
    endtask
    task automatic wr(input logic [3:0] i, input logic [15:0] v);
        @(posedge ref_clk) reg_wr <= 1'b1;
        reg_addr <= i;
        reg_wdata <= v;
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    task automatic go(input opaddr_pkg::addr_mode_t m, input logic [8:0] f, input logic w,
                      input logic [15:0] v, input logic [17:0] x);
        int n = 0;
        @(posedge ref_clk) op_valid <= 1'b1;
        op_in.mode <= m;
        op_in.field <= f;
        op_in.write <= w;
        op_in.acc <= v;
        op_in.imm <= v;
        exp_q.push_back(x);
        @(posedge ref_clk) op_valid <= 1'b0;
        do @(negedge ref_clk); while (op_done !== 1'b1 && ++n < 9);
        chk({15'h0, op_busy, op_done}, 17'h00001);
    endtask
    // each completion is matched with the oldest note; bit 17 picks result, else bit 0 is refusal
    always @(negedge ref_clk) if (op_done === 1'b1) begin
        e = exp_q.pop_front();
        chk({op_executed, e[17] ? op_result : {15'h0, op_refused}}, e[16:0]);
    end
    // hang guard, the sequence needs about a hundred cycles
    always @(posedge ref_clk) if (++cyc == 3000) begin
        fails++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(4'hb, 16'h0); // unmapped index reads zero
        seed = xs(seed);
        {d, p} = seed;
        a = d[7:0];
        wr(4'h0, {8'h0, a});
        go(opaddr_pkg::M_DIRECT, {1'b0, a}, 1'b1, d, 18'h10000);
        go(opaddr_pkg::M_DIRECT, {1'b1, a}, 1'b1, ~d, 18'h10000);
        go(opaddr_pkg::M_DIRECT, {1'b1, a}, 1'b0, d, {2'b11, ~d});
        @(posedge ref_clk) op_in.step <= opaddr_pkg::STEP_INC;
        go(opaddr_pkg::M_PTR, 9'h0, 1'b0, d, {2'b11, d});
        rd(4'h0, {8'h0, a + 8'h1});
        @(posedge ref_clk) op_in.step <= opaddr_pkg::STEP_NONE;
        go(opaddr_pkg::M_DIRECT, {1'b0, a + 8'h1}, 1'b1, p, 18'h10000);
        go(opaddr_pkg::M_MIND_PTR, 9'h0, 1'b0, d, {2'b11, p ^ 16'hc3a5});
        go(opaddr_pkg::M_MIND_PTR, 9'h0, 1'b0, d, {2'b11, (p + 16'h1) ^ 16'hc3a5});
        go(opaddr_pkg::M_ACC, 9'h0, 1'b0, d, {2'b11, d ^ 16'hc3a5});
        go(opaddr_pkg::M_LIMM, 9'h0, 1'b0, p, {2'b11, p});
        go(opaddr_pkg::M_MIND_PTR, 9'h0, 1'b1, d, 18'h00001);
        go(opaddr_pkg::M_SIMM, 9'h0, 1'b0, d, 18'h00001);
        rd(4'ha, 16'h0004);
        wr(4'h8, 16'h0001);
        rd(4'h8, 16'h0001);
        go(opaddr_pkg::M_DIRECT, 9'h106, 1'b1, d, 18'h10000);
        go(opaddr_pkg::M_DREG, 9'h006, 1'b0, p, {2'b11, d});
        go(opaddr_pkg::M_MIND_DREG, 9'h006, 1'b0, p, {2'b11, d ^ 16'hc3a5});
        go(opaddr_pkg::M_DREG, 9'h006, 1'b0, p, {2'b11, d + 16'h1});
        @(posedge ref_clk) op_in.step <= opaddr_pkg::STEP_LOOP_INC;
        go(opaddr_pkg::M_PTR, 9'h0, 1'b0, p, {2'b11, p + 16'h2});
        rd(4'h0, {8'h0, (a + 8'h1) & 8'hf8 | (a + 8'h2) & 8'h07});
        @(posedge ref_clk) op_in.dst_ptr <= 1'b1;
        op_in.step <= opaddr_pkg::STEP_NONE;
        go(opaddr_pkg::M_SIMM, 9'h0, 1'b0, d, 18'h10000);
        rd(4'h0, {8'h0, d[7:0]});
        @(posedge ref_clk) op_in.cond_en <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            @(posedge ref_clk) flags_in.carry <= c[0];
            op_in.cond <= opaddr_pkg::CC_UNSIGNED_LT_COND;
            go(opaddr_pkg::M_LIMM, 9'h0, 1'b0, d, {1'b0, c[0], 16'h0});
            @(posedge ref_clk) op_in.cond <= opaddr_pkg::CC_UNSIGNED_GE_COND;
            go(opaddr_pkg::M_LIMM, 9'h0, 1'b0, d, {1'b0, !c[0], 16'h0});
            @(posedge ref_clk) op_in.cond <= opaddr_pkg::CC_FALSE;
            go(opaddr_pkg::M_LIMM, 9'h0, 1'b0, d, 18'h0);
        end
        print_verdict();
    end
endmodule // operand_address_generator_test
